// >>> design/cifp_defs.vh
// Constants for the cache inquire and flush pin logic
// What this block does
// - Flush: write back modified, invalidate, acknowledge
// - Flush low at reset fall: three-state test
// - Flush latched on falling edge, taken at boundary
// - Test decision from flush before reset release
// - Hit output on any valid cached line
// - Hit changes edge after strobe, then holds
// - Hit outputs driven except in test mode
// - Modified hit: assert hit-modified, then write back
// - Hit on line being written: no new writeback
// - Hit-modified shows result edge after strobe
// - Clean or miss: hit-modified stays negated
// - Hit-modified drops edge after last burst ready
`ifndef CIFP_DEFS_VH
`define CIFP_DEFS_VH
`define CIFP_BURST_BEATS      3'h4
`define CIFP_ST_IDLE          6'h01
`define CIFP_ST_WAITB         6'h02
`define CIFP_ST_WBREQ         6'h04
`define CIFP_ST_WBRUN         6'h08
`define CIFP_ST_INVAL         6'h10
`define CIFP_ST_ACK           6'h20
`endif

// >>> design/cifp_sync.v
// Two-flip-flop synchroniser for a pin input
`timescale 1ns/1ps
module cifp_sync #(
    parameter RESET_VAL = 1'b1
) (
    input  wire CLK,
    input  wire RESET,
    input  wire d,
    output wire q
);
    reg meta_r;
    reg q_r;
    always @(posedge CLK) begin
        if (RESET) begin
            meta_r <= RESET_VAL;
            q_r    <= RESET_VAL;
        end else begin
            meta_r <= d;
            q_r    <= meta_r;
        end
    end
    assign q = q_r;
endmodule

// >>> design/cifp_top.v
// Cache inquire, hit reporting and flush pin logic
`timescale 1ns/1ps
`include "cifp_defs.vh"
module cifp_top (
    input  wire CLK,
    input  wire RESET,
    input  wire FLUSH_REQ_N,
    input  wire INQUIRE_ADDR_STROBE_N,
    input  wire BURST_READY_N,
    input  wire INSN_BOUNDARY,
    input  wire LOOKUP_HIT,
    input  wire LOOKUP_MODIFIED,
    input  wire LOOKUP_WB_BUSY,
    input  wire WB_GRANT,
    input  wire FLUSH_DIRTY_LEFT,
    input  wire INVAL_DONE,
    input  wire ACK_DONE,
    output wire INQUIRE_HIT_N_O,
    output wire INQUIRE_HIT_N_OE,
    output wire INQUIRE_HIT_MODIFIED_N_O,
    output wire INQUIRE_HIT_MODIFIED_N_OE,
    output wire TEST_MODE,
    output wire WB_START,
    output wire FLUSH_WB_REQ,
    output wire INVAL_ALL,
    output wire FLUSH_ACK_CYCLE,
    output wire FLUSH_BUSY
);
    // ============================================================
    // Pin synchronisers
    // ============================================================
    wire flush_s;
    wire strobe_s;
    wire burst_ready_n_s;

    // Flush sync runs through reset, else the strap level never reaches release
    cifp_sync #(.RESET_VAL(1'b1)) u_sync_flush (
        .CLK(CLK), .RESET(1'b0), .d(FLUSH_REQ_N), .q(flush_s));
    cifp_sync #(.RESET_VAL(1'b1)) u_sync_inquire_addr_strobe_n (
        .CLK(CLK), .RESET(RESET), .d(INQUIRE_ADDR_STROBE_N), .q(strobe_s));
    cifp_sync #(.RESET_VAL(1'b1)) u_sync_burst_ready_n (
        .CLK(CLK), .RESET(RESET), .d(BURST_READY_N), .q(burst_ready_n_s));

    // ============================================================
    // Test-mode strap at reset release
    // ============================================================
    reg reset_d_r;
    reg flush_prev_r;
    reg test_mode_r;

    always @(posedge CLK) begin
        reset_d_r    <= RESET;
        flush_prev_r <= flush_s;
        if (RESET) begin
            test_mode_r <= 1'b0;
        end else if (reset_d_r && !flush_prev_r) begin
            // Flush level from the edge before reset was seen low
            test_mode_r <= 1'b1;
        end
    end

    // ============================================================
    // Flush request latch
    // ============================================================
    reg flush_pend_r;
    reg [5:0] fstate_r;
    reg [5:0] fstate_nxt;
    wire flush_fall = flush_prev_r && !flush_s;
    wire flush_take = flush_pend_r && INSN_BOUNDARY && (fstate_r == `CIFP_ST_IDLE);

    always @(posedge CLK) begin
        if (RESET) begin
            flush_pend_r <= 1'b0;
        end else if (flush_fall && !test_mode_r) begin
            // Set beats a same-cycle take so a new edge is not lost
            flush_pend_r <= 1'b1;
        end else if (flush_take) begin
            flush_pend_r <= 1'b0;
        end
    end

    // ============================================================
    // Inquire response and writeback tracking
    // ============================================================
    reg hit_n_r;
    reg inquire_hit_modified_n_n_r;
    reg wb_start_r;
    reg wb_act_r;
    reg [2:0] beat_r;
    reg strobe_prev_r;
    // Strobe ignored the edge after one is taken and while hit-modified is held
    wire strobe_take = !strobe_s && !strobe_prev_r && inquire_hit_modified_n_n_r && !test_mode_r;
    wire last_beat   = wb_act_r && !burst_ready_n_s && (beat_r == `CIFP_BURST_BEATS - 3'h1);

    always @(posedge CLK) begin
        if (RESET) begin
            hit_n_r       <= 1'b1;
            inquire_hit_modified_n_n_r      <= 1'b1;
            wb_start_r    <= 1'b0;
            wb_act_r      <= 1'b0;
            beat_r        <= 3'h0;
            strobe_prev_r <= 1'b0;
        end else begin
            strobe_prev_r <= !strobe_s;
            wb_start_r    <= 1'b0;
            if (strobe_take) begin
                hit_n_r  <= !LOOKUP_HIT;
                inquire_hit_modified_n_n_r <= !(LOOKUP_HIT && LOOKUP_MODIFIED);
                if (LOOKUP_HIT && LOOKUP_MODIFIED && !LOOKUP_WB_BUSY) begin
                    wb_start_r <= 1'b1;
                    wb_act_r   <= 1'b1;
                    beat_r     <= 3'h0;
                end else if (LOOKUP_HIT && LOOKUP_MODIFIED) begin
                    // Existing writeback ends the hold; no second cycle
                    wb_act_r <= 1'b1;
                    beat_r   <= 3'h0;
                end
            end else if (wb_act_r && !burst_ready_n_s) begin
                if (last_beat) begin
                    inquire_hit_modified_n_n_r <= 1'b1;
                    wb_act_r <= 1'b0;
                end
                beat_r <= beat_r + 3'h1;
            end
        end
    end

    // ============================================================
    // Flush sequence
    // ============================================================
    localparam ST_IDLE  = `CIFP_ST_IDLE;
    localparam ST_WAITB = `CIFP_ST_WAITB;
    localparam ST_WBREQ = `CIFP_ST_WBREQ;
    localparam ST_WBRUN = `CIFP_ST_WBRUN;
    localparam ST_INVAL = `CIFP_ST_INVAL;
    localparam ST_ACK   = `CIFP_ST_ACK;

    reg fwb_r;
    reg finv_r;
    reg fack_r;

    always @* begin
        fstate_nxt = fstate_r;
        case (fstate_r)
            ST_IDLE: begin
                if (flush_take) begin
                    fstate_nxt = ST_WBREQ;
                end
            end
            ST_WBREQ: begin
                if (!FLUSH_DIRTY_LEFT) begin
                    fstate_nxt = ST_INVAL;
                end else if (WB_GRANT) begin
                    fstate_nxt = ST_WBRUN;
                end
            end
            ST_WBRUN: begin
                if (!burst_ready_n_s) begin
                    fstate_nxt = ST_WAITB;
                end
            end
            ST_WAITB: begin
                fstate_nxt = ST_WBREQ;
            end
            ST_INVAL: begin
                if (INVAL_DONE) begin
                    fstate_nxt = ST_ACK;
                end
            end
            ST_ACK: begin
                if (ACK_DONE) begin
                    fstate_nxt = ST_IDLE;
                end
            end
            default: begin
                fstate_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge CLK) begin
        if (RESET) begin
            fstate_r <= ST_IDLE;
            fwb_r    <= 1'b0;
            finv_r   <= 1'b0;
            fack_r   <= 1'b0;
        end else begin
            fstate_r <= fstate_nxt;
            // Request stays up across the settle cycle so it reads as one level
            fwb_r    <= (fstate_nxt == ST_WBREQ) || (fstate_nxt == ST_WBRUN) ||
                        (fstate_nxt == ST_WAITB);
            finv_r   <= (fstate_nxt == ST_INVAL);
            fack_r   <= (fstate_nxt == ST_ACK);
        end
    end

    // ============================================================
    // Outputs
    // ============================================================
    reg oe_r;
    always @(posedge CLK) begin
        if (RESET) begin
            oe_r <= 1'b1;
        end else begin
            oe_r <= !(test_mode_r || (reset_d_r && !flush_prev_r));
        end
    end

    assign INQUIRE_HIT_N_O           = hit_n_r;
    assign INQUIRE_HIT_N_OE          = oe_r;
    assign INQUIRE_HIT_MODIFIED_N_O  = inquire_hit_modified_n_n_r;
    assign INQUIRE_HIT_MODIFIED_N_OE = oe_r;
    assign TEST_MODE                 = test_mode_r;
    assign WB_START                  = wb_start_r;
    assign FLUSH_WB_REQ              = fwb_r;
    assign INVAL_ALL                 = finv_r;
    assign FLUSH_ACK_CYCLE           = fack_r;
    assign FLUSH_BUSY                = flush_pend_r;
endmodule

// >>> dv/cifp_asserts.sv
// Concurrent checks on the inquire and flush pin logic
`timescale 1ns/1ps
module cifp_asserts (
    input wire CLK,
    input wire RESET,
    input wire INQUIRE_ADDR_STROBE_N,
    input wire BURST_READY_N,
    input wire LOOKUP_HIT,
    input wire LOOKUP_MODIFIED,
    input wire LOOKUP_WB_BUSY,
    input wire INQUIRE_HIT_N_O,
    input wire INQUIRE_HIT_N_OE,
    input wire INQUIRE_HIT_MODIFIED_N_O,
    input wire INQUIRE_HIT_MODIFIED_N_OE,
    input wire TEST_MODE,
    input wire WB_START
);
    // ====================
    // Answer edge: pins pass two flops, so three edges after the pin
    reg  [3:0] eh_r;
    wire       ans = eh_r[3:2] == 2'h2;
    always @(posedge CLK) begin
        eh_r <= {eh_r[2:0], INQUIRE_ADDR_STROBE_N};
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    a_hit_change_time: assert property ($changed(INQUIRE_HIT_N_O) |-> ans)
        else $error("hit moved off answer edge");
    a_inquire_hit_modified_n_set_time: assert property ($fell(INQUIRE_HIT_MODIFIED_N_O) |-> ans)
        else $error("hit-modified set off answer edge");
    a_hit_value: assert property (ans && $past(INQUIRE_HIT_MODIFIED_N_O) && !TEST_MODE
        |-> INQUIRE_HIT_N_O == !$past(LOOKUP_HIT)) else $error("hit value wrong");
    a_inquire_hit_modified_n_value: assert property (ans && $past(INQUIRE_HIT_MODIFIED_N_O) && !TEST_MODE
        |-> INQUIRE_HIT_MODIFIED_N_O == !($past(LOOKUP_HIT) && $past(LOOKUP_MODIFIED)))
        else $error("hit-modified value wrong");
    a_wb_after_inquire_hit_modified_n: assert property ($fell(INQUIRE_HIT_MODIFIED_N_O)
        && !$past(LOOKUP_WB_BUSY) |-> WB_START) else $error("writeback missing");
    a_no_extra_wb: assert property (WB_START |-> $fell(INQUIRE_HIT_MODIFIED_N_O)
        && !$past(LOOKUP_WB_BUSY)) else $error("writeback not wanted");
    a_inquire_hit_modified_n_drop: assert property ($rose(INQUIRE_HIT_MODIFIED_N_O)
        |-> !$past(BURST_READY_N, 3)) else $error("hit-modified dropped early");
    a_oe_float: assert property (INQUIRE_HIT_N_OE == !TEST_MODE
        && INQUIRE_HIT_MODIFIED_N_OE == !TEST_MODE) else $error("enable wrong");
endmodule
bind cifp_top cifp_asserts u_chk (.*);

// >>> dv/cifp_chipset.sv
// Chipset-side model driving inquire, burst ready and flush pins
`timescale 1ns/1ps
module cifp_chipset (
    input  wire CLK,
    output reg  strobe_n,
    output reg  burst_ready_n_n,
    output reg  flush_n
);
    // ====================
    // Pin tasks, all entered at a falling edge
    initial begin
        strobe_n = 1'h1;
        burst_ready_n_n = 1'h1;
        flush_n = 1'h1;
    end
    // Address bus is taken as held while the strobe is low
    task inq;
        strobe_n = 1'h0;
        @(negedge CLK);
        strobe_n = 1'h1;
    endtask
    // Beats of the running writeback; no new cycle strobe awaited
    task burst(input integer gap);
        repeat (4) begin
            if (gap > 0) begin
                burst_ready_n_n = 1'h1;
                repeat (gap) @(negedge CLK);
            end
            burst_ready_n_n = 1'h0;
            @(negedge CLK);
        end
        burst_ready_n_n = 1'h1;
    endtask
    // Two clocks low keeps it legal both ways
    task flush;
        flush_n = 1'h0;
        repeat (2) @(negedge CLK);
        flush_n = 1'h1;
    endtask
endmodule

// >>> dv/cifp_top_tb.sv
// Self-checking bench for the inquire and flush pin logic
`timescale 1ns/1ps
module cifp_top_tb;
    reg        clk = 1'h0;
    reg        rst, bnd, hit, mod, busy, grant, dirty, inv_done, ack_done;
    wire       strobe_n, burst_ready_n_n, flush_n, hit_o, hit_oe, inquire_hit_modified_n_o, inquire_hit_modified_n_oe;
    wire       test_mode, wb_start, flush_wb, inval, ack_cyc, busy_o;
    wire [2:0] ph = {ack_cyc, inval, flush_wb};
    reg  [31:0] r;
    integer    seed, i, n, cyc = 0, fails = 0, checks = 0;
    always #10 clk = ~clk;
    cifp_chipset p (.CLK(clk), .strobe_n(strobe_n), .burst_ready_n_n(burst_ready_n_n), .flush_n(flush_n));
    cifp_top dut (.CLK(clk), .RESET(rst), .FLUSH_REQ_N(flush_n),
        .INQUIRE_ADDR_STROBE_N(strobe_n), .BURST_READY_N(burst_ready_n_n), .INSN_BOUNDARY(bnd),
        .LOOKUP_HIT(hit), .LOOKUP_MODIFIED(mod), .LOOKUP_WB_BUSY(busy), .WB_GRANT(grant),
        .FLUSH_DIRTY_LEFT(dirty), .INVAL_DONE(inv_done), .ACK_DONE(ack_done),
        .INQUIRE_HIT_N_O(hit_o), .INQUIRE_HIT_N_OE(hit_oe), .INQUIRE_HIT_MODIFIED_N_O(inquire_hit_modified_n_o),
        .INQUIRE_HIT_MODIFIED_N_OE(inquire_hit_modified_n_oe), .TEST_MODE(test_mode), .WB_START(wb_start),
        .FLUSH_WB_REQ(flush_wb), .INVAL_ALL(inval), .FLUSH_ACK_CYCLE(ack_cyc),
        .FLUSH_BUSY(busy_o));
    // ====================
    // Shared tasks
    task chk(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Take three edges after the pin falls, answer and start pulse on that same edge
    task answer;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task wph(input logic [2:0] e);
        n = 0;
        while (ph !== e && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(ph, e);
        @(negedge clk);
    endtask
    task do_reset;
        rst = 1'h1;
        repeat (10) @(negedge clk);
        rst = 1'h0;
        repeat (3) @(negedge clk);
    endtask
    task end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Hang guard, run needs at most about 1050 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            end_sim;
        end
    end
    // ====================
    // Main sequence
    initial begin
        seed = 52;
        {rst, bnd, hit, mod, busy, grant, dirty, inv_done, ack_done} = 9'h100;
        do_reset;
        for (i = 0; i < 40; i++) begin
            r = $random(seed);
            hit = r[0];
            mod = r[0] & r[1];
            busy = r[2] & r[3];
            p.inq;
            answer;
            chk(hit_o, !hit);
            chk(inquire_hit_modified_n_o, !mod);
            chk(wb_start, mod & !busy);
            if (mod) begin
                @(negedge clk);
                hit = 1'h0;
                mod = 1'h0;
                p.inq;
                answer;
                chk({hit_o, inquire_hit_modified_n_o}, 4'h0);
                @(negedge clk);
                p.burst(r[5:4]);
                @(posedge clk);
                #1;
                chk(inquire_hit_modified_n_o, 1'h0);
                @(posedge clk);
                #1;
                chk(inquire_hit_modified_n_o, 1'h1);
            end
            @(negedge clk);
        end
        dirty = 1'h1;
        p.flush;
        repeat (10) @(negedge clk);
        chk({busy_o, ph}, 4'h8);
        bnd = 1'h1;
        wph(3'h1);
        grant = 1'h1;
        @(negedge clk);
        grant = 1'h0;
        p.burst(1);
        wph(3'h1);
        dirty = 1'h0;
        wph(3'h2);
        inv_done = 1'h1;
        @(negedge clk);
        inv_done = 1'h0;
        wph(3'h4);
        ack_done = 1'h1;
        @(negedge clk);
        ack_done = 1'h0;
        wph(3'h0);
        chk(busy_o, 1'h0);
        p.flush_n = 1'h0;
        do_reset;
        p.flush_n = 1'h1;
        chk({test_mode, hit_oe, inquire_hit_modified_n_oe}, 4'h4);
        do_reset;
        chk({test_mode, hit_oe, inquire_hit_modified_n_oe}, 4'h3);
        end_sim;
    end
endmodule
